// >>> inc/pfr_consts.vh
// Constants for the parity repair framer
// Included by core/pfr_framer.v; defines only
`ifndef PFR_CONSTS_VH
`define PFR_CONSTS_VH
`define PFR_RTP_VERSION    2'h2
`define PFR_FEC_HDR_OCTETS 5'h10
`define PFR_RTP_HDR_OCTETS 5'h0c
`define PFR_CODE_TYPE      3'h0
`define PFR_DIM_MAX        8'hff
`define PFR_RATE_MIN       32'h000003e8
`define PFR_DIM_RST        8'h01
`define PFR_RATE_RST       32'h00015f90
`define PFR_PTYPE_RST      7'h60
`define PFR_TICK_RST       32'h00001458
`define PFR_OFS_CTRL       4'h0
`define PFR_OFS_STATUS     4'h1
`define PFR_OFS_SSRC       4'h2
`define PFR_OFS_SEQ        4'h3
`define PFR_OFS_DIM        4'h4
`define PFR_OFS_RATE       4'h5
`define PFR_OFS_PTYPE      4'h6
`define PFR_OFS_TSTICK     4'h7
`define PFR_OFS_SEQSEED    4'h8
`define PFR_LFSR_SEED      32'h5a5a1234
`define PFR_LFSR_TAPS      32'h80200003
`define PFR_ST_IDLE        2'h0
`define PFR_ST_ACC         2'h1
`define PFR_ST_HDR         2'h2
`define PFR_ST_PAY         2'h3
`endif

// >>> core/pfr_framer.v
// Repair packet framer: accumulates protected source packets by XOR, then
// emits RTP header, 16-octet FEC header and repair payload as a byte stream.
// Assumes the source side marks header fields and payload bytes per packet.
//
// Overview of operation
// - Repair RTP header version field is always two.
// - Repair P bit is XOR of protected source P bits.
// - Repair X bit is XOR of protected source X bits.
// - Repair CC field is XOR of protected source CC values.
// - Repair M bit is XOR of protected source M bits.
// - No padding, extension or CSRC list is ever emitted.
// - Each repair sequence number is previous plus one, wrapping.
// - Initial sequence number should come from an unpredictable value.
// - Repair timestamp reflects the moment of transmission.
// - SSRC is random; collisions resolved by software reassignment.
// - Payload covers CSRC, extension, payload and padding of sources.
// - A 16-octet FEC header follows every repair RTP header.
// - Sequence base is lowest source sequence number, wrap-aware.
// - Recovery fields carry XOR of length, payload type, timestamp.
// - Column count L and row count D go into their fields.
// - Mask, D bit, index and extended base are sent as zero.
// - Second extension flag is reserved and sent as zero.
// - Code-type field carries the single defined code value.
// - Column count must be 1 to 255, else rejected.
// - Row count must be 1 to 255, else rejected.
// - Timestamp rate must exceed 1000 Hz, else rejected.
`timescale 1ns/1ps
`include "pfr_consts.vh"
module pfr_framer #(
	parameter MAX_LEN = 2048,
	parameter LEN_W   = 11
) (
	clk,
	nrst,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	src_start,
	src_hdr,
	src_len,
	src_byte_vld,
	src_byte,
	src_last,
	rep_vld,
	rep_byte,
	rep_first,
	rep_last,
	rep_busy,
	cfg_err
);
	input  wire        clk;
	input  wire        nrst;
	input  wire [3:0]  reg_addr;
	input  wire [31:0] reg_wdata;
	input  wire        reg_wr;
	input  wire        reg_rd;
	output reg  [31:0] reg_rdata;
	// Header fields: {p,x,cc[3:0],m,pt[6:0],unused bit,seq[15:0],ts[31:0]}
	input  wire        src_start;
	input  wire [62:0] src_hdr;
	input  wire [15:0] src_len;
	input  wire        src_byte_vld;
	input  wire [7:0]  src_byte;
	input  wire        src_last;
	output reg         rep_vld;
	output reg  [7:0]  rep_byte;
	output reg         rep_first;
	output reg         rep_last;
	output reg         rep_busy;
	output reg         cfg_err;

	reg  [7:0]       acc_mem [0:MAX_LEN-1];
	reg  [1:0]       st_r;
	reg              enable_r;
	reg  [31:0]      ssrc_r;
	reg  [15:0]      seq_r;
	reg  [7:0]       cols_r;
	reg  [7:0]       rows_r;
	reg  [31:0]      rate_r;
	reg  [6:0]       ptype_r;
	reg  [31:0]      ts_r;
	reg  [31:0]      tick_r;
	reg  [31:0]      tick_cnt_r;
	reg  [31:0]      lfsr_r;
	reg  [7:0]       pkt_cnt_r;
	reg  [LEN_W-1:0] pos_r;
	reg  [LEN_W-1:0] max_len_r;
	reg              x_p_r;
	reg              x_x_r;
	reg  [3:0]       x_cc_r;
	reg              x_m_r;
	reg  [6:0]       x_pt_r;
	reg  [31:0]      x_ts_r;
	reg  [15:0]      x_len_r;
	reg  [15:0]      base_r;
	reg  [4:0]       hdr_idx_r;
	reg  [95:0]      rtp_hdr_r;
	reg  [127:0]     fec_hdr_r;
	reg  [7:0]       rd_byte_r;
	reg              first_src_r;
	wire             cfg_ok;
	wire [15:0]      base_diff;

	// A difference with top bit set means the new number lies behind
	function seq_older;
		input [15:0] a;
		input [15:0] b;
		reg   [15:0] d;
		begin
			d = a - b;
			seq_older = d[15];
		end
	endfunction

	assign cfg_ok = (cols_r != 8'h00) && (rows_r != 8'h00) &&
		(rate_r > `PFR_RATE_MIN);
	assign base_diff = src_hdr[47:32] - base_r;

	// Register port, read data one cycle after the strobe
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h0;
			enable_r  <= 1'b0;
			ssrc_r    <= 32'h0;
			cols_r    <= `PFR_DIM_RST;
			rows_r    <= `PFR_DIM_RST;
			rate_r    <= `PFR_RATE_RST;
			ptype_r   <= `PFR_PTYPE_RST;
			tick_r    <= `PFR_TICK_RST;
			cfg_err   <= 1'b0;
		end else begin
			cfg_err <= enable_r & ~cfg_ok;
			if (reg_wr) begin
				case (reg_addr)
				`PFR_OFS_CTRL: begin
					enable_r <= reg_wdata[0];
				end
				`PFR_OFS_SSRC: begin
					ssrc_r <= reg_wdata;
				end
				`PFR_OFS_DIM: begin
					cols_r <= reg_wdata[7:0];
					rows_r <= reg_wdata[15:8];
				end
				`PFR_OFS_RATE: begin
					rate_r <= reg_wdata;
				end
				`PFR_OFS_PTYPE: begin
					ptype_r <= reg_wdata[6:0];
				end
				`PFR_OFS_TSTICK: begin
					tick_r <= reg_wdata;
				end
				default: begin
				end
				endcase
			end
			if (reg_rd) begin
				case (reg_addr)
				`PFR_OFS_CTRL:    reg_rdata <= {31'h0, enable_r};
				`PFR_OFS_STATUS:  reg_rdata <= {28'h0, ~cfg_ok, rep_busy, st_r};
				`PFR_OFS_SSRC:    reg_rdata <= ssrc_r;
				`PFR_OFS_SEQ:     reg_rdata <= {16'h0, seq_r};
				`PFR_OFS_DIM:     reg_rdata <= {16'h0, rows_r, cols_r};
				`PFR_OFS_RATE:    reg_rdata <= rate_r;
				`PFR_OFS_PTYPE:   reg_rdata <= {25'h0, ptype_r};
				`PFR_OFS_TSTICK:  reg_rdata <= tick_r;
				`PFR_OFS_SEQSEED: reg_rdata <= lfsr_r;
				default:          reg_rdata <= 32'h0;
				endcase
			end else begin
				reg_rdata <= 32'h0;
			end
		end
	end

	// Free-running media clock; software sets clk cycles per tick from rate
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ts_r       <= 32'h0;
			tick_cnt_r <= 32'h0;
			lfsr_r     <= `PFR_LFSR_SEED;
		end else begin
			lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ `PFR_LFSR_TAPS) : (lfsr_r >> 1);
			if (tick_cnt_r + 32'h1 >= tick_r) begin
				tick_cnt_r <= 32'h0;
				ts_r       <= ts_r + 32'h1;
			end else begin
				tick_cnt_r <= tick_cnt_r + 32'h1;
			end
		end
	end

	// Accumulator array; not reset, cleared by first packet of each block
	always @(posedge clk) begin
		if (st_r == `PFR_ST_ACC && src_byte_vld) begin
			acc_mem[pos_r] <= first_src_r ? src_byte
				: (((pos_r < max_len_r) ? acc_mem[pos_r] : 8'h00) ^ src_byte);
		end
		rd_byte_r <= (pos_r < max_len_r) ? acc_mem[pos_r] : 8'h00;
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r        <= `PFR_ST_IDLE;
			seq_r       <= 16'h0;
			pkt_cnt_r   <= 8'h0;
			pos_r       <= {LEN_W{1'b0}};
			max_len_r   <= {LEN_W{1'b0}};
			first_src_r <= 1'b1;
			x_p_r       <= 1'b0;
			x_x_r       <= 1'b0;
			x_cc_r      <= 4'h0;
			x_m_r       <= 1'b0;
			x_pt_r      <= 7'h0;
			x_ts_r      <= 32'h0;
			x_len_r     <= 16'h0;
			base_r      <= 16'h0;
			hdr_idx_r   <= 5'h0;
			rtp_hdr_r   <= 96'h0;
			fec_hdr_r   <= 128'h0;
			rep_vld     <= 1'b0;
			rep_byte    <= 8'h0;
			rep_first   <= 1'b0;
			rep_last    <= 1'b0;
			rep_busy    <= 1'b0;
		end else begin
			rep_vld   <= 1'b0;
			rep_first <= 1'b0;
			rep_last  <= 1'b0;
			case (st_r)
			`PFR_ST_IDLE: begin
				rep_busy <= 1'b0;
				if (!enable_r) begin
					seq_r <= lfsr_r[15:0];
				end else if (cfg_ok) begin
					st_r        <= `PFR_ST_ACC;
					pkt_cnt_r   <= 8'h0;
					first_src_r <= 1'b1;
					max_len_r   <= {LEN_W{1'b0}};
				end
			end
			`PFR_ST_ACC: begin
				if (src_start) begin
					pos_r  <= {LEN_W{1'b0}};
					x_p_r  <= (first_src_r ? 1'b0 : x_p_r) ^ src_hdr[62];
					x_x_r  <= (first_src_r ? 1'b0 : x_x_r) ^ src_hdr[61];
					x_cc_r <= (first_src_r ? 4'h0 : x_cc_r) ^ src_hdr[60:57];
					x_m_r  <= (first_src_r ? 1'b0 : x_m_r) ^ src_hdr[56];
					x_pt_r <= (first_src_r ? 7'h0 : x_pt_r) ^ src_hdr[55:49];
					x_ts_r <= (first_src_r ? 32'h0 : x_ts_r) ^ src_hdr[31:0];
					x_len_r <= (first_src_r ? 16'h0 : x_len_r) ^ src_len;
					if (first_src_r || base_diff[15]) begin
						base_r <= src_hdr[47:32];
					end
				end else if (src_byte_vld) begin
					pos_r <= pos_r + {{(LEN_W-1){1'b0}}, 1'b1};
					if (pos_r >= max_len_r) begin
						max_len_r <= pos_r + {{(LEN_W-1){1'b0}}, 1'b1};
					end
					if (src_last) begin
						first_src_r <= 1'b0;
						pkt_cnt_r   <= pkt_cnt_r + 8'h1;
						if (pkt_cnt_r + 8'h1 == rows_r) begin
							st_r      <= `PFR_ST_HDR;
							rep_busy  <= 1'b1;
							hdr_idx_r <= 5'h0;
							// Header fields beyond the XORs come from registers and counters; no
							// CSRC, extension or padding follows
							rtp_hdr_r <= {`PFR_RTP_VERSION, x_p_r, x_x_r, x_cc_r,
								x_m_r, ptype_r, seq_r, ts_r, ssrc_r};
							fec_hdr_r <= {base_r, x_len_r, 1'b1, x_pt_r, 24'h0,
								x_ts_r, 1'b0, 1'b0, `PFR_CODE_TYPE, 3'h0,
								cols_r, rows_r, 8'h0};
						end
					end
				end
			end
			`PFR_ST_HDR: begin
				rep_vld   <= 1'b1;
				rep_first <= (hdr_idx_r == 5'h0);
				if (hdr_idx_r < `PFR_RTP_HDR_OCTETS) begin
					rep_byte  <= rtp_hdr_r[95:88];
					rtp_hdr_r <= {rtp_hdr_r[87:0], 8'h0};
				end else begin
					rep_byte  <= fec_hdr_r[127:120];
					fec_hdr_r <= {fec_hdr_r[119:0], 8'h0};
				end
				pos_r <= {LEN_W{1'b0}};
				if (hdr_idx_r == `PFR_RTP_HDR_OCTETS + `PFR_FEC_HDR_OCTETS - 5'h1) begin
					st_r <= `PFR_ST_PAY;
				end else begin
					hdr_idx_r <= hdr_idx_r + 5'h1;
				end
			end
			`PFR_ST_PAY: begin
				// Read latency of one cycle; pos_r leads rd_byte_r by one
				pos_r <= pos_r + {{(LEN_W-1){1'b0}}, 1'b1};
				if (pos_r != {LEN_W{1'b0}}) begin
					rep_vld  <= 1'b1;
					rep_byte <= rd_byte_r;
					if (pos_r == max_len_r) begin
						rep_last <= 1'b1;
						seq_r    <= seq_r + 16'h1;
						st_r     <= `PFR_ST_IDLE;
					end
				end
			end
			default: begin
				st_r <= `PFR_ST_IDLE;
			end
			endcase
		end
	end
endmodule // pfr_framer

// >>> tb/pfr_checker_properties.sv
// Checker: concurrent properties on the framer ports
// Bound to pfr_framer from the testbench top file
`timescale 1ns/1ps
module pfr_checker (
	input wire        clk,
	input wire        nrst,
	input wire [3:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire        rep_vld,
	input wire [7:0]  rep_byte,
	input wire        rep_first,
	input wire        rep_last
);
	reg  [15:0] pos_r;
	reg  [15:0] dim_r;
	reg  [7:0]  hi_r;
	reg  [15:0] seq_r;
	reg         seen_r;
	wire [15:0] idx = rep_first ? 16'h0 : pos_r;
	// Byte index tracked by count, since gaps inside a packet are legal
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pos_r <= 16'h0;
			dim_r <= 16'h0101;
			hi_r <= 8'h0;
			seq_r <= 16'h0;
			seen_r <= 1'b0;
		end else begin
			if (rep_vld)
				pos_r <= idx + 16'h1;
			if (reg_wr && reg_addr == 4'h4)
				dim_r <= reg_wdata[15:0];
			if (rep_vld && idx == 16'h2)
				hi_r <= rep_byte;
			if (rep_vld && idx == 16'h3) begin
				seq_r <= {hi_r, rep_byte};
				seen_r <= 1'b1;
			end
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_version_two: assert property (rep_first |-> rep_vld && rep_byte[7:6] == 2'h2)
		else $error("bad version");
	a_hdr_min: assert property (rep_last |-> rep_vld && idx >= 16'h1c)
		else $error("short repair packet");
	a_mask_zero: assert property (rep_vld && idx > 16'h10 && idx < 16'h14 |-> rep_byte == 8'h0)
		else $error("mask not zero");
	a_type_code: assert property (rep_vld && idx == 16'h18 |-> rep_byte == 8'h00)
		else $error("bad type byte");
	a_ext_base: assert property (rep_vld && idx == 16'h1b |-> rep_byte == 8'h00)
		else $error("ext base not zero");
	a_col_count: assert property (rep_vld && idx == 16'h19 |-> rep_byte == dim_r[7:0])
		else $error("bad column count");
	a_row_count: assert property (rep_vld && idx == 16'h1a |-> rep_byte == dim_r[15:8])
		else $error("bad row count");
	a_seq_step: assert property (rep_vld && idx == 16'h3 && seen_r |-> {hi_r, rep_byte} == seq_r + 16'h1)
		else $error("sequence step wrong");
endmodule // pfr_checker

// >>> tb/pfr_rx_model.sv
// Receiver model: collects repair bytes into a queue
// Stream has no back-pressure, so the model only listens
`timescale 1ns/1ps
module pfr_rx_model (
	input wire       clk,
	input wire       rep_vld,
	input wire [7:0] rep_byte,
	input wire       rep_last
);
	logic [7:0] q[$];
	integer     npkt = 0;
	// Mask, index and extended base kept but never interpreted
	// Each packet taken at once; no waiting past the window
	always @(posedge clk) begin
		if (rep_vld)
			q.push_back(rep_byte);
		if (rep_vld && rep_last)
			npkt = npkt + 1;
	end
endmodule // pfr_rx_model

// >>> tb/test_parity_fec_repair_framer.sv
// Testbench: framer against an integer model of each repair packet
// Needs pfr_framer, pfr_rx_model and pfr_checker compiled first
`timescale 1ns/1ps
bind pfr_framer pfr_checker chk_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .rep_vld(rep_vld), .rep_byte(rep_byte),
	.rep_first(rep_first), .rep_last(rep_last));
module test_parity_fec_repair_framer;
	reg          clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, src_start = 1'b0;
	reg          src_byte_vld = 1'b0, src_last = 1'b0;
	reg  [3:0]   reg_addr = 4'h0;
	reg  [31:0]  reg_wdata = 32'h0, prev_ts = 32'h0;
	reg  [62:0]  src_hdr = 63'h0, hx;
	reg  [15:0]  src_len = 16'h0, lx, base;
	reg  [7:0]   src_byte = 8'h0, e;
	reg  [7:0]   pay [0:15];
	reg  [223:0] hv;
	wire [31:0]  reg_rdata;
	wire [7:0]   rep_byte;
	wire         rep_vld, rep_last, cfg_err;
	integer      err_total = 0, n_checks = 0, seed = 32'h4476, plen, prev_seq = -1, i, k;
	localparam [31:0] SSRC = 32'h1a2b3c4d;
	pfr_framer dut_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_start(src_start),
		.src_hdr(src_hdr), .src_len(src_len), .src_byte_vld(src_byte_vld),
		.src_byte(src_byte), .src_last(src_last), .rep_vld(rep_vld), .rep_byte(rep_byte),
		.rep_first(), .rep_last(rep_last), .rep_busy(), .cfg_err(cfg_err));
	pfr_rx_model rx_u (.clk(clk), .rep_vld(rep_vld), .rep_byte(rep_byte), .rep_last(rep_last));
	initial forever #2.5 clk = ~clk;
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd(input [3:0] a, input [31:0] x, input s);
		begin
			// Top bit carries the expected error flag; rate writes drop it
			if (s)
				wr(a, (a == 4'h5) ? {1'b0, x[30:0]} : x);
			else
				reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1 chk(s ? cfg_err : reg_rdata, s ? {31'h0, x[31]} : x);
			@(posedge clk);
		end
	endtask
	task send(input [15:0] sq);
		reg [62:0] h;
		reg [7:0]  b;
		integer    n, j;
		begin
			h = {$random(seed), $random(seed)};
			h[62] = 1'b0;
			h[47:32] = sq;
			n = 1 + ($random(seed) & 15);
			src_start <= 1'b1;
			src_hdr <= h;
			src_len <= n[15:0] + 16'h0c;
			@(posedge clk);
			src_start <= 1'b0;
			for (j = 0; j < n; j = j + 1) begin
				b = $random(seed);
				src_byte_vld <= 1'b1;
				src_byte <= b;
				src_last <= (j == n - 1);
				pay[j] = pay[j] ^ b;
				@(posedge clk);
			end
			src_byte_vld <= 1'b0;
			src_last <= 1'b0;
			hx = hx ^ h;
			lx = lx ^ (n[15:0] + 16'h0c);
			if (n > plen)
				plen = n;
			// Wrap-aware minimum: lower when the difference has its top bit set
			if (sq - base >= 16'h8000)
				base = sq;
		end
	endtask
	task blk(input [7:0] d, input [15:0] s0, input [15:0] st);
		integer n0, t;
		begin
			wr(4'h4, {16'h0, d, 8'h04});
			hx = 63'h0;
			lx = 16'h0;
			plen = 0;
			base = s0;
			for (i = 0; i < 16; i = i + 1)
				pay[i] = 8'h0;
			n0 = rx_u.npkt;
			rx_u.q.delete();
			for (k = 0; k < d; k = k + 1)
				send(s0 + k * st);
			for (t = 0; t < 3000 && rx_u.npkt == n0; t = t + 1)
				@(posedge clk);
			hv = {2'h2, hx[62:56], 7'h65, 48'h0, SSRC, base, lx, 1'b1, hx[55:49], 24'h0,
				hx[31:0], 8'h00, 8'h04, d, 8'h00};
			chk(rx_u.q.size(), 28 + plen);
			for (i = 0; i < 28; i = i + 1) begin
				e = hv[223 - 8 * i -: 8];
				if (i < 2 || i > 7) chk(rx_u.q[i], e);
			end
			chk({rx_u.q[8], rx_u.q[9], rx_u.q[10], rx_u.q[11]}, SSRC);
			chk({rx_u.q[12], rx_u.q[13], rx_u.q[25], rx_u.q[26]}, {base, 8'h04, d});
			chk({rx_u.q[20], rx_u.q[21], rx_u.q[22], rx_u.q[23]}, hx[31:0]);
			for (i = 0; i < plen; i = i + 1)
				chk(rx_u.q[28 + i], pay[i]);
			if (prev_seq >= 0) chk({rx_u.q[2], rx_u.q[3]}, (prev_seq + 1) & 32'hffff);
			if (prev_seq >= 0) chk({rx_u.q[4], rx_u.q[5], rx_u.q[6], rx_u.q[7]} > prev_ts, 1);
			prev_seq = {rx_u.q[2], rx_u.q[3]};
			prev_ts = {rx_u.q[4], rx_u.q[5], rx_u.q[6], rx_u.q[7]};
			$display("block of %0d rows done", d);
			repeat (4) @(posedge clk);
		end
	endtask
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(4'h4, 32'h0101, 1'b0);
		rd(4'h5, 32'h00015f90, 1'b0);
		rd(4'h6, 32'h60, 1'b0);
		rd(4'h7, 32'h1458, 1'b0);
		rd(4'h9, 32'h0, 1'b0);
		wr(4'h2, SSRC);
		wr(4'h6, 32'h65);
		wr(4'h7, 32'h4);
		wr(4'h0, 32'h1);
		rd(4'h2, SSRC, 1'b0);
		$display("register test done");
		blk(8'h03, 16'hfffe, 16'h0001);
		blk(8'h02, 16'h0011, 16'hffff);
		blk(8'h01, 16'h1234, 16'h0001);
		rd(4'h4, 32'h80000004, 1'b1);
		rd(4'h4, 32'h80000200, 1'b1);
		rd(4'h4, 32'h0000ffff, 1'b1);
		rd(4'h5, 32'h800003e8, 1'b1);
		rd(4'h5, 32'h000003e9, 1'b1);
		$display("config test done");
		end_sim;
	end
	initial begin
		#100000;
		err_total = err_total + 1;
		end_sim;
	end
endmodule // test_parity_fec_repair_framer
